/* File: rtl/adc_ctrl_pkg.sv */
// Constants for the converter output and power control block
package adc_ctrl_pkg;
  localparam int SAMPLE_WIDTH = 14;
  localparam int PIPE_LATENCY = 5;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_WIDTH = SAMPLE_WIDTH + 1;
  localparam int SAMPLE_MSB = SAMPLE_WIDTH - 1;
  localparam logic [SAMPLE_WIDTH-1:0] MID_SCALE = 14'h2000;
  localparam logic [SAMPLE_WIDTH-1:0] FULL_POS = 14'h3fff;
  localparam logic [SAMPLE_WIDTH-1:0] FULL_NEG = 14'h0000;
  localparam logic [1:0] FORMAT_LEVEL_GND = 2'h0;
  localparam logic [1:0] FORMAT_LEVEL_THIRD = 2'h1;
  localparam logic [1:0] FORMAT_LEVEL_TWO_THIRDS = 2'h2;
  localparam logic [1:0] FORMAT_LEVEL_SUPPLY = 2'h3;
  localparam real CLK_PERIOD_NS = 25.0;

  typedef enum logic [1:0] {
    PWR_NORMAL_DRIVEN = 2'b00,
    PWR_NORMAL_HIZ = 2'b01,
    PWR_SLEEP = 2'b11,
    PWR_NAP = 2'b10
  } power_state_t;
endpackage : adc_ctrl_pkg

/* File: rtl/adc_output_power_control.sv */
// Sample pipeline, output format, overflow flag and power state control
// Notes on behaviour
// - New sample taken on rising clock edge
// - Select low, enable low: convert, drive outputs
// - Select low, enable high: convert, outputs hi-Z
// - Select high, enable low: nap, outputs hi-Z
// - Select high, enable high: sleep, outputs hi-Z
// - Result appears five clocks after its sample
// - Fourteen-bit word, top line is MSB
// - Overflow flag high beyond either full scale
// - Format pin picks coding and stabilizer
`timescale 1ns/1ps

module sample_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Write side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Read side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_params
    $error("sample_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  // One spare pointer bit tells full from empty
  logic [AW:0] wrPtr_ff;
  logic [AW:0] rdPtr_ff;
  logic doWrite;
  logic doRead;

  assign inReady = (wrPtr_ff - rdPtr_ff) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_ff != rdPtr_ff;
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outData = mem_ff[rdPtr_ff[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (doWrite) begin
      mem_ff[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wrPtr_ff <= '0;
    end else if (doWrite) begin
      wrPtr_ff <= wrPtr_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdPtr_ff <= '0;
    end else if (doRead) begin
      rdPtr_ff <= rdPtr_ff + 1'b1;
    end
  end
endmodule : sample_fifo

module adc_output_power_control #(
  parameter int LATENCY = adc_ctrl_pkg::PIPE_LATENCY,
  parameter int DEPTH = adc_ctrl_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Quantized input: raw offset-binary code plus over/under range
  input wire logic [adc_ctrl_pkg::SAMPLE_WIDTH-1:0] analogCode,
  input wire logic analogOver,
  input wire logic analogUnder,
  // Static control pins
  input wire logic powerDownSelect,
  input wire logic outputEnableN,
  input wire logic [1:0] formatLevel,
  // Output pins, enable low while driving
  output logic [adc_ctrl_pkg::SAMPLE_WIDTH-1:0] sampleWordOut,
  output logic [adc_ctrl_pkg::SAMPLE_WIDTH-1:0] sampleWordOutEnN,
  output logic rangeOverflowFlag,
  output logic rangeOverflowFlagEnN,
  // Status
  output adc_ctrl_pkg::power_state_t powerState,
  output logic dutyStabilizerOn,
  output logic wordValid,
  output logic fifoOverrun
);
  import adc_ctrl_pkg::*;

  // Refuse shapes the pipeline and buffer cannot serve
  if (LATENCY < 3) begin : g_bad_latency
    $error("adc_output_power_control: latency must be at least 3");
  end
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("adc_output_power_control: depth must be a power of two of at least 2");
  end

  logic converting;
  logic driveEnable;
  logic twosComp;
  logic [SAMPLE_WIDTH-1:0] codedWord;
  logic [LATENCY-2:0] validPipe_ff;
  logic [SAMPLE_WIDTH:0] dataPipe_ff [LATENCY-1];
  logic fifoInReady;
  logic fifoOutValid;
  logic [FIFO_WIDTH-1:0] fifoOutData;
  logic outTake;

  // Power state decode from the two static pins
  always_comb begin
    unique case ({powerDownSelect, outputEnableN})
      2'b00: powerState = PWR_NORMAL_DRIVEN;
      2'b01: powerState = PWR_NORMAL_HIZ;
      2'b10: powerState = PWR_NAP;
      2'b11: powerState = PWR_SLEEP;
    endcase
  end

  assign converting = !powerDownSelect;
  assign driveEnable = powerState == PWR_NORMAL_DRIVEN;

  // Middle levels run the stabilizer, upper two levels give two's complement
  assign twosComp = formatLevel[1];
  assign dutyStabilizerOn = (formatLevel == FORMAT_LEVEL_THIRD) ||
                            (formatLevel == FORMAT_LEVEL_TWO_THIRDS);

  // Saturate out-of-range inputs, then apply the chosen coding
  always_comb begin
    codedWord = analogCode;
    if (analogOver) begin
      codedWord = FULL_POS;
    end else if (analogUnder) begin
      codedWord = FULL_NEG;
    end
    if (twosComp) begin
      codedWord = codedWord ^ MID_SCALE;
    end
  end

  // Sample stage plus LATENCY-2 stages; the buffer and then the output register follow
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      validPipe_ff <= '0;
    end else begin
      validPipe_ff <= {validPipe_ff[LATENCY-3:0], converting};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (converting) begin
      dataPipe_ff[0] <= {analogOver || analogUnder, codedWord};
    end
  end

  genvar s;
  generate
    for (s = 1; s < LATENCY - 1; s++) begin : g_stage
      always_ff @(posedge ref_clk) begin
        dataPipe_ff[s] <= dataPipe_ff[s-1];
      end
    end
  endgenerate

  // Buffer drained every cycle: a word reaching a stopped output is
  // dropped, so every shown word keeps its fixed latency
  sample_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .inValid(validPipe_ff[LATENCY-2]),
    .inReady(fifoInReady),
    .inData(dataPipe_ff[LATENCY-2]),
    .outValid(fifoOutValid),
    .outReady(1'b1),
    .outData(fifoOutData)
  );

  assign fifoOverrun = validPipe_ff[LATENCY-2] && !fifoInReady;

  // Output stage takes a buffered word only while converting
  assign outTake = fifoOutValid && converting;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sampleWordOut <= '0;
    end else if (outTake) begin
      sampleWordOut <= fifoOutData[SAMPLE_MSB:0];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rangeOverflowFlag <= 1'b0;
    end else if (outTake) begin
      rangeOverflowFlag <= fifoOutData[SAMPLE_WIDTH];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wordValid <= 1'b0;
    end else begin
      wordValid <= outTake;
    end
  end

  // Enables follow the pins with no delay
  assign sampleWordOutEnN = {SAMPLE_WIDTH{!driveEnable}};
  assign rangeOverflowFlagEnN = !driveEnable;
endmodule : adc_output_power_control

/* File: testbench/adc_ctrl_asserts.sv */
// Port checks for the converter control block
`timescale 1ns/1ps
module adc_ctrl_checker
  import adc_ctrl_pkg::*;
(
  // Pins in
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [13:0] analogCode,
  input wire logic analogOver,
  input wire logic analogUnder,
  input wire logic powerDownSelect,
  input wire logic outputEnableN,
  input wire logic [1:0] formatLevel,
  // Pins out
  input wire logic [13:0] sampleWordOut,
  input wire logic [13:0] sampleWordOutEnN,
  input wire logic rangeOverflowFlag,
  input wire logic rangeOverflowFlagEnN,
  input wire power_state_t powerState,
  input wire logic dutyStabilizerOn,
  input wire logic wordValid,
  input wire logic fifoOverrun
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  function automatic logic [13:0] fmt(logic [13:0] c, logic o, logic u, logic [1:0] f);
    return (o ? 14'h3fff : u ? 14'h0 : c) ^ {f[1], 13'h0};
  endfunction : fmt
  drive_on_a:
    assert property (!powerDownSelect && !outputEnableN |-> !(|sampleWordOutEnN)
      && !rangeOverflowFlagEnN) else $error("not driven");
  hiz_conv_a:
    assert property (!powerDownSelect && outputEnableN |-> &sampleWordOutEnN
      && rangeOverflowFlagEnN && powerState == PWR_NORMAL_HIZ) else $error("bad hiz");
  nap_state_a:
    assert property (powerDownSelect && !outputEnableN |-> &sampleWordOutEnN
      && powerState == PWR_NAP) else $error("bad nap");
  sleep_state_a:
    assert property (powerDownSelect && outputEnableN |-> &sampleWordOutEnN
      && powerState == PWR_SLEEP) else $error("bad sleep");
  halt_hold_a:
    assert property (powerDownSelect [*2] |-> !wordValid && $stable(sampleWordOut))
      else $error("no halt");
  pipe_word_a:
    assert property ((!powerDownSelect && $stable(formatLevel)) [*7] |-> wordValid
      && sampleWordOut == fmt($past(analogCode, 6), $past(analogOver, 6),
      $past(analogUnder, 6), formatLevel)) else $error("bad word");
  range_flag_a:
    assert property ((!powerDownSelect) [*7] |-> rangeOverflowFlag ==
      ($past(analogOver, 6) | $past(analogUnder, 6))) else $error("bad flag");
  duty_sel_a:
    assert property (dutyStabilizerOn == formatLevel inside {2'h1, 2'h2}) else $error("duty");
  stop_idle_a:
    assert property (powerDownSelect |=> !wordValid) else $error("valid after stop");
  no_overrun_a:
    assert property (!fifoOverrun) else $error("buffer overrun");
  cover property (wordValid && $past(powerDownSelect, 2));
  cover property (powerDownSelect ##1 !powerDownSelect);
  cover property (analogOver && analogUnder);
  cover property (wordValid && !outputEnableN && formatLevel == 2'h3);
endmodule : adc_ctrl_checker

/* File: testbench/adc_output_power_control_tb.sv */
// Random and corner stimulus with scoreboard
`timescale 1ns/1ps
module adc_output_power_control_tb;
  import adc_ctrl_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, analogOver = 1'b0, analogUnder = 1'b0;
  logic powerDownSelect = 1'b0, outputEnableN = 1'b0;
  logic [13:0] analogCode = 14'h0, sampleWordOut, sampleWordOutEnN, capWord;
  logic [1:0] formatLevel = 2'h0;
  logic rangeOverflowFlag, rangeOverflowFlagEnN, dutyStabilizerOn, wordValid, capStrobe;
  power_state_t powerState;
  int numErrors = 0, testsRun = 0, cycles = 0, seed = 32'h4323;
  logic fifoOverrun;
  logic [15:0] hist[6];
  adc_output_power_control u_adc_output_power_control (.*);
  capture_model u_capture_model (.ref_clk(ref_clk), .wordPins(sampleWordOut),
    .wordEnN(sampleWordOutEnN), .wordValid(wordValid), .powerDownSelect(powerDownSelect),
    .capStrobe(capStrobe), .capWord(capWord));
  function automatic logic [14:0] exp_word(logic [13:0] c, logic o, logic u, logic [1:0] f);
    return {o | u, (o ? 14'h3fff : u ? 14'h0 : c) ^ {f[1], 13'h0}};
  endfunction : exp_word
  task automatic chk(logic [14:0] got, logic [14:0] exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("errors=%0d checks=%0d", numErrors, testsRun);
    if (numErrors == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Scoreboard on pre-edge outputs; hist[k] is {converting, word} of edge n-1-k
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 1000) begin
      numErrors++;
      results();
    end else if (reset) begin
      if (cycles > 1) chk({rangeOverflowFlag, sampleWordOut}, 15'h0);
      if (cycles > 1) chk(15'(wordValid), 15'h0);
      for (int k = 0; k < 6; k++) hist[k] = '0;
    end else begin
      chk(15'(wordValid), 15'(hist[5][15] && hist[0][15]));
      chk(15'(fifoOverrun), 15'h0);
      if (hist[5][15] && hist[0][15]) begin
        chk({rangeOverflowFlag, sampleWordOut}, hist[5][14:0]);
        if (capStrobe) chk({rangeOverflowFlag, capWord}, hist[5][14:0]);
      end
      for (int k = 5; k > 0; k--) hist[k] = hist[k-1];
      hist[0] = {!powerDownSelect, exp_word(analogCode, analogOver, analogUnder, formatLevel)};
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #2 reset = 1'b0;
    for (int p = 0; p < 32; p++) begin
      if (p == 16) begin
        @(posedge ref_clk);
        #2 reset = 1'b1;
        repeat (2) @(posedge ref_clk);
        #2 reset = 1'b0;
      end
      for (int i = 0; i < 14; i++) begin
        @(posedge ref_clk);
        #2;
        powerDownSelect = (i < 3);
        outputEnableN = (i < 3) ? p[0] : (i > 11 && p[1]);
        if (i == 0) formatLevel = p[3:2];
        analogCode = (i == 5) ? {p[0], 13'h0} : 14'($random(seed));
        analogOver = ($random(seed) & 7) == 0;
        analogUnder = ($random(seed) & 7) == 1;
        if (i == 6) {analogOver, analogUnder} = p[1:0];
        #1;
        chk(15'(powerState), 15'({powerDownSelect, outputEnableN}));
        chk({rangeOverflowFlagEnN, sampleWordOutEnN}, {15{powerDownSelect | outputEnableN}});
        chk(15'(dutyStabilizerOn), 15'(formatLevel inside {2'h1, 2'h2}));
      end
    end
    results();
  end
endmodule : adc_output_power_control_tb
bind adc_output_power_control adc_ctrl_checker u_adc_ctrl_checker (.*);

/* File: testbench/capture_model.sv */
// Downstream capture logic
`timescale 1ns/1ps
module capture_model (
  // Converter side
  input wire logic ref_clk,
  input wire logic [13:0] wordPins,
  input wire logic [13:0] wordEnN,
  input wire logic wordValid,
  input wire logic powerDownSelect,
  // Captured word
  output logic capStrobe,
  output logic [13:0] capWord
);
  logic [13:0] lastWord = 14'h0;
  // Released lines float away from the last level
  assign capWord = (wordPins & ~wordEnN) | (~lastWord & wordEnN);
  assign capStrobe = wordValid && !powerDownSelect && wordEnN == 14'h0;
  always @(posedge ref_clk) lastWord <= capWord;
endmodule : capture_model
